// ==== verilog/dpack_top.sv ====
// Top of the dual-port acknowledge, memory timing and refresh test logic.
module dpack_top
#(
    parameter int unsigned ADDR_W = 8
)
(
    // Clock and reset
    input  wire  logic                          clk,
    input  wire  logic                          rst,
    // Configuration
    input  wire  dpack_pkg::dpack_cfg_type      cfg,
    input  wire  dpack_pkg::dpack_port_cfg_type cfg_a,
    input  wire  dpack_pkg::dpack_port_cfg_type cfg_b,
    // Port A requester
    input  wire  logic                          req_a,
    input  wire  logic                          port_qualify_a_n,
    input  wire  logic                          cmd_active_a,
    // Port B requester
    input  wire  logic                          req_b,
    input  wire  logic                          port_qualify_b_n,
    input  wire  logic                          cmd_active_b,
    // Refresh
    input  wire  logic                          refresh_req,
    // Acknowledges
    output dpack_pkg::dpack_ack_type            ack_a,
    output dpack_pkg::dpack_ack_type            ack_b,
    // Memory side
    output logic                                ras_out,
    output logic                                cas_out,
    output logic                                port_select_out,
    output logic [ADDR_W-1:0]                   addr_out,
    output logic                                refresh_addr_on,
    output logic                                init_active
);

    // ------------------------------------------------------------------
    // Memory cycle timing
    // ------------------------------------------------------------------
    dpack_pkg::dpack_state_type state_r;
    dpack_pkg::dpack_state_type state_nxt;
    logic [3:0]                 cyc_cnt_r;
    logic                       owner_b_r;
    logic                       is_refresh_r;
    logic                       refresh_pend_r;
    logic [15:0]                rfc_r;
    logic                       init_r;
    logic                       init_seen_r;
    logic                       want_a;
    logic                       want_b;

    wire [3:0] cyc_len = dpack_pkg::CYC_BASE
                       + (cfg.memory_speed_bit ? dpack_pkg::CYC_SLOW_RAM_ADD : 4'h0)
                       + (cfg.cycle_lengthen_bit ? dpack_pkg::CYC_EXT_ADD : 4'h0);
    wire [3:0] cas_at  = cfg.cycle_lengthen_bit ? dpack_pkg::CAS_STEP_EXT
                                                : dpack_pkg::CAS_STEP;
    wire idle      = (state_r == dpack_pkg::DPACK_IDLE);
    wire rf_go     = idle & (refresh_pend_r | init_r);
    wire grant_a   = idle & ~rf_go & want_a;
    wire grant_b   = idle & ~rf_go & ~want_a & want_b;
    wire start     = rf_go | grant_a | grant_b;
    wire ras_edge  = (state_r == dpack_pkg::DPACK_RUN) & (cyc_cnt_r == dpack_pkg::RAS_STEP);
    wire cyc_end   = (state_r == dpack_pkg::DPACK_RUN) & (cyc_cnt_r == cyc_len);
    wire end_a     = cyc_end & ~is_refresh_r & ~owner_b_r;
    wire end_b     = cyc_end & ~is_refresh_r & owner_b_r;
    wire ras_a     = ras_edge & ~is_refresh_r & ~owner_b_r;
    wire ras_b     = ras_edge & ~is_refresh_r & owner_b_r;
    wire rf_update = cyc_end & is_refresh_r;
    wire init_done = init_r & rf_update & (rfc_r == 16'hFFFF);

    // Split mode: each half counts alone, so no carry crosses between them.
    wire [7:0]  rfc_lo_inc = rfc_r[7:0] + 8'h01;
    wire [7:0]  rfc_hi_inc = rfc_r[15:8] + 8'h01;
    wire [15:0] rfc_split  = {rfc_hi_inc, rfc_lo_inc};
    wire [15:0] rfc_inc    = rfc_r + 16'h0001;
    wire [15:0] rfc_next   = cfg.test_split ? rfc_split : rfc_inc;
    wire        row_phase  = (cyc_cnt_r < cas_at);
    wire [7:0]  rf_addr    = row_phase ? rfc_r[15:8] : rfc_r[7:0];

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            dpack_pkg::DPACK_IDLE:
                if (start)
                    state_nxt = dpack_pkg::DPACK_RUN;
            dpack_pkg::DPACK_RUN:
                if (cyc_end)
                    state_nxt = dpack_pkg::DPACK_HOLD;
            dpack_pkg::DPACK_HOLD:
                state_nxt = dpack_pkg::DPACK_IDLE;
            default:
                state_nxt = dpack_pkg::DPACK_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r      <= dpack_pkg::DPACK_IDLE;
            cyc_cnt_r    <= 4'h0;
            owner_b_r    <= 1'b0;
            is_refresh_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (start)
            begin
                cyc_cnt_r    <= 4'h0;
                owner_b_r    <= grant_b;
                is_refresh_r <= rf_go;
            end
            else if (state_r == dpack_pkg::DPACK_RUN)
                cyc_cnt_r <= cyc_cnt_r + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Refresh counter, initialization and test modes
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            refresh_pend_r <= 1'b0;
            rfc_r          <= dpack_pkg::RFC_RESET;
            init_r         <= 1'b0;
            init_seen_r    <= 1'b0;
        end
        else
        begin
            init_seen_r <= 1'b1;
            // A new request in the same cycle as the service start is kept.
            if (refresh_req)
                refresh_pend_r <= 1'b1;
            else if (rf_go)
                refresh_pend_r <= 1'b0;
            if (~init_seen_r)
            begin
                // Settings are caught on the first clock after reset release.
                init_r <= cfg.ecc_on & ~cfg.test_split;
                if (cfg.test_preset)
                    rfc_r <= dpack_pkg::RFC_NEAR_ROLL;
            end
            else
            begin
                if (rf_update)
                    rfc_r <= rfc_next;
                if (init_done | cfg.test_split)
                    init_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Port instances
    // ------------------------------------------------------------------
    dpack_port u_port_a
    (
        .clk            (clk),
        .rst            (rst),
        .cfg            (cfg),
        .pcfg           (cfg_a),
        .req            (req_a),
        .port_qualify_n (port_qualify_a_n),
        .cmd_active     (cmd_active_a),
        .grant          (grant_a),
        .ras_edge       (ras_a),
        .cycle_end      (end_a),
        .want           (want_a),
        .ack            (ack_a)
    );

    dpack_port u_port_b
    (
        .clk            (clk),
        .rst            (rst),
        .cfg            (cfg),
        .pcfg           (cfg_b),
        .req            (req_b),
        .port_qualify_n (port_qualify_b_n),
        .cmd_active     (cmd_active_b),
        .grant          (grant_b),
        .ras_edge       (ras_b),
        .cycle_end      (end_b),
        .want           (want_b),
        .ack            (ack_b)
    );

    // ------------------------------------------------------------------
    // Memory side outputs
    // ------------------------------------------------------------------
    wire running = (state_r == dpack_pkg::DPACK_RUN);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ras_out         <= 1'b0;
            cas_out         <= 1'b0;
            port_select_out <= 1'b1;
            addr_out        <= '0;
            refresh_addr_on <= 1'b0;
            init_active     <= 1'b0;
        end
        else
        begin
            ras_out <= running & (cyc_cnt_r >= dpack_pkg::RAS_STEP);
            cas_out <= running & (cyc_cnt_r >= cas_at);
            if (grant_a | grant_b)
                port_select_out <= grant_a;
            addr_out        <= (running & is_refresh_r) ? ADDR_W'(rf_addr) : '0;
            refresh_addr_on <= running & is_refresh_r;
            init_active     <= init_r;
        end
    end

endmodule : dpack_top

// ==== verilog/dpack_pkg.sv ====
// Package of constants and carrier types for the dual-port acknowledge logic.
package dpack_pkg;

    // ------------------------------------------------------------------
    // Timing counts in controller clocks
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ          = 40;
    localparam logic [2:0]  ADV_LEN_FAST     = 3'h3;
    localparam logic [2:0]  ADV_LEN_SLOW     = 3'h2;
    localparam logic [3:0]  CYC_BASE         = 4'h5;
    localparam logic [3:0]  CYC_SLOW_RAM_ADD = 4'h1;
    localparam logic [3:0]  CYC_EXT_ADD      = 4'h2;
    localparam logic [3:0]  RAS_STEP         = 4'h1;
    localparam logic [3:0]  CAS_STEP         = 4'h2;
    localparam logic [3:0]  CAS_STEP_EXT     = 4'h3;
    localparam logic [3:0]  DATA_AFTER_ADV   = 4'h2;
    localparam int unsigned SYNC_STAGES      = 2;

    // ------------------------------------------------------------------
    // Refresh counter layout and test presets
    // ------------------------------------------------------------------
    localparam int unsigned RFC_W            = 16;
    localparam int unsigned RFC_HALF         = 8;
    localparam logic [15:0] RFC_RESET        = 16'h0000;
    localparam logic [15:0] RFC_NEAR_ROLL    = 16'hFFF0;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic fast_cycle_select;
        logic cycle_lengthen_bit;
        logic memory_speed_bit;
        logic ecc_on;
        logic test_split;
        logic test_preset;
    } dpack_cfg_type;

    typedef struct packed {
        logic sync_select;
        logic ack_is_transfer;
    } dpack_port_cfg_type;

    typedef struct packed {
        logic advance_done_strobe;
        logic transfer_done_strobe;
        logic early_advance_done;
        logic late_advance_done;
        logic data_valid;
    } dpack_ack_type;

    typedef enum logic [1:0] {
        DPACK_IDLE,
        DPACK_RUN,
        DPACK_HOLD
    } dpack_state_type;

endpackage : dpack_pkg

// ==== verilog/dpack_port.sv ====
// One port's request qualification and acknowledge generation.
module dpack_port
(
    // Clock and reset
    input  wire  logic                         clk,
    input  wire  logic                         rst,
    // Configuration
    input  wire  dpack_pkg::dpack_cfg_type     cfg,
    input  wire  dpack_pkg::dpack_port_cfg_type pcfg,
    // Requester side
    input  wire  logic                         req,
    input  wire  logic                         port_qualify_n,
    input  wire  logic                         cmd_active,
    // Memory timing from the shared generator
    input  wire  logic                         grant,
    input  wire  logic                         ras_edge,
    input  wire  logic                         cycle_end,
    // Results
    output logic                               want,
    output dpack_pkg::dpack_ack_type           ack
);

    // ------------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------------
    logic [dpack_pkg::SYNC_STAGES-1:0] sync_r;
    logic                              req_prev_r;
    logic                              pending_r;
    logic                              served_r;
    logic [2:0]                        adv_cnt_r;
    logic [3:0]                        data_cnt_r;
    logic                              xfer_r;
    logic                              dv_r;
    logic                              adv_fast_pend_r;

    wire req_seen  = pcfg.sync_select ? req : sync_r[dpack_pkg::SYNC_STAGES-1];
    wire req_rise  = req_seen & ~req_prev_r;
    wire start_ok  = req_rise & ~port_qualify_n;
    wire is_xfer   = cfg.ecc_on & pcfg.ack_is_transfer;
    wire fast_path = ~cfg.ecc_on & cfg.fast_cycle_select & ~cfg.memory_speed_bit
                     & ~cfg.cycle_lengthen_bit;
    wire mine_ras  = served_r & ras_edge;
    wire adv_now   = mine_ras & ~is_xfer & ~fast_path;
    wire adv_late  = adv_fast_pend_r;
    wire adv_start = adv_now | adv_late;
    wire [2:0] adv_len = cfg.fast_cycle_select ? dpack_pkg::ADV_LEN_FAST
                                               : dpack_pkg::ADV_LEN_SLOW;

    assign want = pending_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync_r          <= '0;
            req_prev_r      <= 1'b0;
            pending_r       <= 1'b0;
            served_r        <= 1'b0;
            adv_cnt_r       <= 3'h0;
            data_cnt_r      <= 4'h0;
            xfer_r          <= 1'b0;
            dv_r            <= 1'b0;
            adv_fast_pend_r <= 1'b0;
        end
        else
        begin
            sync_r     <= {sync_r[dpack_pkg::SYNC_STAGES-2:0], req};
            req_prev_r <= req_seen;
            // An aborted request never becomes pending, so no strobe follows.
            if (start_ok)
                pending_r <= 1'b1;
            else if (grant)
                pending_r <= 1'b0;
            if (grant)
                served_r <= 1'b1;
            else if (cycle_end)
                served_r <= 1'b0;
            adv_fast_pend_r <= mine_ras & ~is_xfer & fast_path;
            // The start edge itself is the first strobe clock, so the count holds the rest.
            if (adv_start)
                adv_cnt_r <= adv_len - 3'h1;
            else if (adv_cnt_r != 3'h0)
                adv_cnt_r <= adv_cnt_r - 3'h1;
            if (adv_start)
                data_cnt_r <= dpack_pkg::DATA_AFTER_ADV - 4'h1;
            else if (data_cnt_r != 4'h0)
                data_cnt_r <= data_cnt_r - 4'h1;
            if (served_r & cycle_end & (~cfg.ecc_on | is_xfer))
                xfer_r <= 1'b1;
            else if (~cmd_active)
                xfer_r <= 1'b0;
            // Early strobe holds data until the command drops; late drops at cycle end.
            if (data_cnt_r == 4'h1)
                dv_r <= 1'b1;
            else if (pcfg.sync_select ? ~cmd_active : cycle_end)
                dv_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Acknowledge outputs
    // ------------------------------------------------------------------
    // The strobe flop rises on the start edge: the row strobe edge, or one clock later on the fast path.
    wire adv_on = (adv_cnt_r != 3'h0) | adv_start;

    always_ff @(posedge clk)
    begin
        if (rst)
            ack <= '0;
        else
        begin
            ack.advance_done_strobe  <= adv_on;
            ack.early_advance_done   <= adv_on & pcfg.sync_select;
            ack.late_advance_done    <= adv_on & ~pcfg.sync_select;
            ack.transfer_done_strobe <= xfer_r & cmd_active;
            ack.data_valid           <= dv_r;
        end
    end

endmodule : dpack_port

// ==== bench/dpack_top_asserts.sv ====
// Concurrent checks bound to the ports of the dual-port acknowledge logic.
module dpack_top_asserts
#(
    parameter int unsigned ADDR_W = 8
)
(
    // Clock and reset
    input  wire  logic                          clk,
    input  wire  logic                          rst,
    // Configuration and requests
    input  wire  dpack_pkg::dpack_cfg_type      cfg,
    input  wire  dpack_pkg::dpack_port_cfg_type cfg_a,
    input  wire  dpack_pkg::dpack_port_cfg_type cfg_b,
    input  wire  logic                          req_a,
    input  wire  logic                          port_qualify_a_n,
    input  wire  logic                          cmd_active_a,
    input  wire  logic                          req_b,
    input  wire  logic                          port_qualify_b_n,
    input  wire  logic                          cmd_active_b,
    input  wire  logic                          refresh_req,
    // Outputs under watch
    input  wire  dpack_pkg::dpack_ack_type      ack_a,
    input  wire  dpack_pkg::dpack_ack_type      ack_b,
    input  wire  logic                          ras_out,
    input  wire  logic                          cas_out,
    input  wire  logic                          port_select_out,
    input  wire  logic [ADDR_W-1:0]             addr_out,
    input  wire  logic                          refresh_addr_on,
    input  wire  logic                          init_active
);
    default clocking dpack_cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Acknowledge and initialization checks, with covers
    // ------------------------------------------------------------------
    chk_adv_len_slow: assert property (
        $rose(ack_a.advance_done_strobe) && !cfg.fast_cycle_select
        |-> ack_a.advance_done_strobe[*2] ##1 !ack_a.advance_done_strobe)
        else $error("port A advance strobe not two clocks long");
    chk_adv_len_fast: assert property (
        $rose(ack_b.advance_done_strobe) && cfg.fast_cycle_select
        |-> ack_b.advance_done_strobe[*3] ##1 !ack_b.advance_done_strobe)
        else $error("port B advance strobe not three clocks long");
    chk_adv_slow_ras: assert property (
        $rose(ras_out) && port_select_out && !refresh_addr_on && !cfg.ecc_on
        && !cfg.fast_cycle_select && !cfg.cycle_lengthen_bit
        |-> $rose(ack_a.advance_done_strobe))
        else $error("slow advance strobe not with row strobe");
    chk_adv_fast_ras: assert property (
        $rose(ras_out) && port_select_out && !refresh_addr_on && !cfg.ecc_on
        && cfg.fast_cycle_select && !cfg.cycle_lengthen_bit
        |-> ##[0:1] $rose(ack_a.advance_done_strobe))
        else $error("fast advance strobe missing after row strobe");
    chk_data_after_adv: assert property (
        $rose(ack_a.advance_done_strobe) |-> ##2 $rose(ack_a.data_valid))
        else $error("read data not valid two clocks after advance strobe");
    chk_xfer_release: assert property (
        !cmd_active_a |=> !ack_a.transfer_done_strobe)
        else $error("transfer strobe held with command inactive");
    chk_abort_quiet: assert property (
        $rose(req_a) && port_qualify_a_n && cfg_a.sync_select
        |=> (!ack_a.advance_done_strobe && !ack_a.transfer_done_strobe)[*8])
        else $error("aborted request was acknowledged");
    chk_split_no_init: assert property (
        cfg.test_split |-> !init_active)
        else $error("initialization ran in split counter mode");

    cover property ($rose(ack_a.transfer_done_strobe));
    cover property ($rose(ack_b.late_advance_done));
    cover property ($rose(refresh_addr_on) && cfg.test_split);
endmodule : dpack_top_asserts

bind dpack_top dpack_top_asserts #(.ADDR_W(ADDR_W)) u_dpack_asserts
(
    .clk(clk), .rst(rst), .cfg(cfg), .cfg_a(cfg_a), .cfg_b(cfg_b), .req_a(req_a),
    .port_qualify_a_n(port_qualify_a_n), .cmd_active_a(cmd_active_a), .req_b(req_b),
    .port_qualify_b_n(port_qualify_b_n), .cmd_active_b(cmd_active_b),
    .refresh_req(refresh_req), .ack_a(ack_a), .ack_b(ack_b), .ras_out(ras_out),
    .cas_out(cas_out), .port_select_out(port_select_out), .addr_out(addr_out),
    .refresh_addr_on(refresh_addr_on), .init_active(init_active)
);

// ==== bench/dpack_cpu_model.sv ====
// Requester model standing at one port of the dual-port acknowledge logic.
module dpack_cpu_model
(
    // Clock
    input  wire  logic                     clk,
    // Acknowledge bundle from the port
    input  wire  dpack_pkg::dpack_ack_type ack,
    // Request lines
    output logic                           req,
    output logic                           port_qualify_n,
    output logic                           cmd_active
);
    timeunit 1ns;
    timeprecision 1ps;

    int   adv_len;
    int   dv_off;
    logic xfer_seen;
    logic xfer_left;
    logic early_seen;
    logic late_seen;

    initial
    begin
        req            = 1'b0;
        port_qualify_n = 1'b1;
        cmd_active     = 1'b0;
    end

    // ------------------------------------------------------------------
    // One access; qualify stays low for qual_hold edges, none when zero.
    // ------------------------------------------------------------------
    task automatic access(input int qual_hold, input int wait_max, input bit want_xfer);
        int adv_on;
        adv_on     = -1;
        adv_len    = 0;
        dv_off     = -1;
        xfer_seen  = 1'b0;
        early_seen = 1'b0;
        late_seen  = 1'b0;
        @(posedge clk) #1 req = 1'b1;
        cmd_active     = 1'b1;
        port_qualify_n = (qual_hold == 0);
        for (int n = 1; n <= wait_max; n++)
        begin
            @(posedge clk) #1;
            if (n == qual_hold) port_qualify_n = 1'b1;
            if (ack.advance_done_strobe && adv_on < 0) adv_on = n;
            if (ack.data_valid && dv_off < 0 && adv_on >= 0) dv_off = n - adv_on;
            adv_len    += ack.advance_done_strobe;
            early_seen |= ack.early_advance_done;
            late_seen  |= ack.late_advance_done;
            xfer_seen  |= ack.transfer_done_strobe;
            if (want_xfer ? xfer_seen : (dv_off >= 0 && !ack.advance_done_strobe)) break;
        end
        req            = 1'b0;
        cmd_active     = 1'b0;
        port_qualify_n = 1'b1;
        repeat (2) @(posedge clk);
        #1 xfer_left = ack.transfer_done_strobe;
    endtask : access
endmodule : dpack_cpu_model

// ==== bench/dpack_top_tb_top.sv ====
// Self-checking bench for the dual-port acknowledge logic.
module dpack_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int ADDR_W = 8;
    localparam int LIMIT  = 20000;

    logic                          clk, rst, refresh_req;
    logic                          req_a, port_qualify_a_n, cmd_active_a;
    logic                          req_b, port_qualify_b_n, cmd_active_b;
    logic                          ras_out, cas_out, port_select_out, refresh_addr_on;
    logic                          init_active, ras_q, adv_q;
    logic [ADDR_W-1:0]             addr_out;
    dpack_pkg::dpack_cfg_type      cfg;
    dpack_pkg::dpack_port_cfg_type cfg_a, cfg_b;
    dpack_pkg::dpack_ack_type      ack_a, ack_b;
    int                            miscompares, n_compared, cyc, t_ras, t_adv, d;
    logic [7:0]                    row, col, prow, pcol;

    dpack_top #(.ADDR_W(ADDR_W)) u_dut
    (
        .clk(clk), .rst(rst), .cfg(cfg), .cfg_a(cfg_a), .cfg_b(cfg_b),
        .req_a(req_a), .port_qualify_a_n(port_qualify_a_n), .cmd_active_a(cmd_active_a),
        .req_b(req_b), .port_qualify_b_n(port_qualify_b_n), .cmd_active_b(cmd_active_b),
        .refresh_req(refresh_req), .ack_a(ack_a), .ack_b(ack_b), .ras_out(ras_out),
        .cas_out(cas_out), .port_select_out(port_select_out), .addr_out(addr_out),
        .refresh_addr_on(refresh_addr_on), .init_active(init_active)
    );
    dpack_cpu_model u_cpu_a (.clk(clk), .ack(ack_a), .req(req_a),
                             .port_qualify_n(port_qualify_a_n), .cmd_active(cmd_active_a));
    dpack_cpu_model u_cpu_b (.clk(clk), .ack(ack_b), .req(req_b),
                             .port_qualify_n(port_qualify_b_n), .cmd_active(cmd_active_b));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    // Configuration is only changed while reset is held.
    task automatic restart(input logic [5:0] c, input logic sa, sb, ta, input int n);
        @(posedge clk) #1 rst = 1'b1;
        cfg   = c;
        cfg_a = {sa, ta};
        cfg_b = {sb, 1'b0};
        repeat (n) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk) #1;
    endtask : restart

    task automatic get_refresh(output logic [7:0] r, output logic [7:0] c);
        int k;
        k = 0;
        while (!(ras_out && refresh_addr_on && !cas_out) && k < 200) @(posedge clk) #1 k++;
        r = addr_out;
        while (!cas_out && k < 200) @(posedge clk) #1 k++;
        c = addr_out;
        while (ras_out && k < 200) @(posedge clk) #1 k++;
        check(k < 200, 32'h1);
    endtask : get_refresh

    task automatic refresh_run(input int n, input bit split);
        for (int i = 0; i < n; i++)
        begin
            prow = row;
            pcol = col;
            @(posedge clk) #1 refresh_req = 1'b1;
            @(posedge clk) #1 refresh_req = 1'b0;
            get_refresh(row, col);
            if (split && i > 0) check({row, col}, {prow + 8'h1, pcol + 8'h1});
            if (!split && i > 0) check({row, col}, {prow, pcol} + 16'h1);
        end
    endtask : refresh_run

    always @(posedge clk)
    begin
        #1;
        cyc++;
        if (ras_out && !ras_q && !refresh_addr_on && port_select_out) t_ras = cyc;
        if (ack_a.advance_done_strobe && !adv_q) t_adv = cyc;
        ras_q = ras_out;
        adv_q = ack_a.advance_done_strobe;
        if (cyc == LIMIT)
        begin
            miscompares++;
            $display("mismatch at %0t: run too long", $time);
            end_sim();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rst         = 1'b1;
        refresh_req = 1'b0;
        cfg         = '0;
        cfg_a       = '0;
        cfg_b       = '0;
        restart(6'h00, 1'b1, 1'b0, 1'b0, 12);
        u_cpu_a.access(99, 30, 1'b1);
        check(u_cpu_a.adv_len, 32'h2);
        check(u_cpu_a.dv_off, 32'h2);
        check(u_cpu_a.xfer_seen, 32'h1);
        check(u_cpu_a.xfer_left, 32'h0);
        check({u_cpu_a.early_seen, u_cpu_a.late_seen}, 32'h2);
        check(t_adv - t_ras, 32'h0);
        u_cpu_a.access(0, 16, 1'b1);
        check({u_cpu_a.adv_len[3:0], u_cpu_a.xfer_seen}, 32'h0);
        u_cpu_b.access(1, 16, 1'b1);
        check({u_cpu_b.adv_len[3:0], u_cpu_b.xfer_seen}, 32'h0);
        u_cpu_b.access(4, 30, 1'b1);
        check({u_cpu_b.early_seen, u_cpu_b.late_seen}, 32'h1);
        fork
            u_cpu_a.access(99, 40, 1'b1);
            u_cpu_b.access(99, 40, 1'b1);
        join
        check({u_cpu_a.adv_len[3:0], u_cpu_b.adv_len[3:0]}, 32'h22);
        check({u_cpu_a.xfer_seen, u_cpu_b.xfer_seen}, 32'h3);
        // Fast cycle with both memory speeds: exactly one gives the later strobe.
        for (int ms = 0; ms < 2; ms++)
        begin
            restart({2'h2, ms[0], 3'h0}, 1'b1, 1'b0, 1'b0, 2);
            u_cpu_a.access(99, 30, 1'b1);
            check(u_cpu_a.adv_len, 32'h3);
            d += t_adv - t_ras;
            u_cpu_b.access(99, 30, 1'b1);
            check(u_cpu_b.adv_len, 32'h3);
        end
        check(d, 32'h1);
        restart(6'h05, 1'b1, 1'b0, 1'b1, 2);
        get_refresh(row, col);
        check({row, col}, 32'hFFF0);
        repeat (400) if (init_active) @(posedge clk) #1;
        check(init_active, 32'h0);
        u_cpu_a.access(99, 30, 1'b1);
        check({u_cpu_a.adv_len[3:0], u_cpu_a.xfer_seen}, 32'h1);
        u_cpu_b.access(99, 30, 1'b0);
        check({u_cpu_b.adv_len[3:0], u_cpu_b.xfer_seen, u_cpu_b.late_seen}, 32'h9);
        check(u_cpu_b.dv_off, 32'h2);
        restart(6'h02, 1'b1, 1'b0, 1'b0, 2);
        check(init_active, 32'h0);
        refresh_run(260, 1'b1);
        restart(6'h00, 1'b1, 1'b0, 1'b0, 2);
        refresh_run(260, 1'b0);
        end_sim();
    end
endmodule : dpack_top_tb_top
